//--- ipc_cfg.svh
// Constants of the infrared pulse codec, with the list of its behaviours
// Function
// - Transmit high pulse ends after three sub-bit clocks or the 4 us limiter.
// - Half duplex: the infrared side never transmits and receives together.
// - Host start-bit falling edge starts encoding; bits follow every 16 sub-bit clocks.
// - Decoded start bit aligns to infrared falling edge; bits follow every 16.
// - Transmit output held low while a receive low pulse is present.
// - Reset held stops the state machine; no encoding or decoding.
// - Zero bit: low 7, high 3, low 6 sub-bit clocks; one bit: low 16.
// - Low pulse at bit start decodes zero, steady high one; held 16 clocks.
// - In reset the host serial output is high, the infrared output low.
`ifndef IPC_CFG_SVH
`define IPC_CFG_SVH
`define IPC_CLK_MHZ 125
`define IPC_LIMIT_NS 4000
`define IPC_TICK_LAST 4'hF
`define IPC_PULSE_FIRST 4'h7
`define IPC_PULSE_LAST 4'h9
`define IPC_RX_WIN_LAST 4'h2
`define IPC_FRAME_LAST 4'h9
`define IPC_LIM_W 9
`endif

//--- ipc_pkg.sv
// Types of the infrared pulse codec
`include "ipc_cfg.svh"
package ipc_pkg;
    typedef enum logic [1:0] {
        IPC_IDLE = 2'b00,
        IPC_BUSY = 2'b01
    } ipc_dir_state_t;

    typedef struct packed {
        logic clk_d1;
        ipc_dir_state_t tx_st;
        logic [3:0] tx_tick;
        logic [3:0] tx_bit;
        logic tx_zero;
        logic [`IPC_LIM_W-1:0] lim_cnt;
        ipc_dir_state_t rx_st;
        logic [3:0] rx_tick;
        logic [3:0] rx_bit;
        logic host_rx;
        logic ir_out;
    } ipc_state_t;

    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
    } ipc_sync_state_t;
endpackage : ipc_pkg

//--- ipc_sync.sv
// Two-stage synchroniser for the pins that arrive from outside the clock domain
module ipc_sync import ipc_pkg::*; (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [2:0] pins_i,
    output logic [2:0] pins_o
);
    ipc_sync_state_t st_q;
    ipc_sync_state_t st_d;

    always_comb begin
        st_d = st_q;
        st_d.s1 = pins_i;
        // Stage one feeds stage two only
        for (int i = 0; i < 3; i++) begin
            st_d.s2[i] = st_q.s1[i];
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            st_q <= '{s1: 3'h7, s2: 3'h7};
        end else begin
            st_q <= st_d;
        end
    end

    assign pins_o = st_q.s2;
endmodule : ipc_sync

//--- ipc_codec.sv
// Half-duplex infrared pulse encoder and decoder between host serial and transceiver
`include "ipc_cfg.svh"
module ipc_codec import ipc_pkg::*; (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic bit_clock_x16_i,
    input wire logic host_tx_i,
    input wire logic ir_pulse_in_i,
    output logic host_rx_o,
    output logic ir_pulse_out_o
);
    localparam int unsigned LimitCyc = (`IPC_LIMIT_NS * `IPC_CLK_MHZ) / 1000;
    localparam logic [`IPC_LIM_W-1:0] LimitCnt = LimitCyc[`IPC_LIM_W-1:0];

    logic [2:0] pins_s;
    logic clk_s;
    logic host_tx_s;
    logic ir_in_s;
    logic tick;
    logic pulse_win;
    ipc_state_t st_q;
    ipc_state_t st_d;

    ipc_sync u_sync (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .pins_i({bit_clock_x16_i, host_tx_i, ir_pulse_in_i}),
        .pins_o(pins_s)
    );

    assign clk_s = pins_s[2];
    assign host_tx_s = pins_s[1];
    assign ir_in_s = pins_s[0];
    // One sub-bit clock period begins at each rising edge of the bit clock
    assign tick = clk_s & ~st_q.clk_d1;
    assign pulse_win = (st_q.tx_st == IPC_BUSY) && st_q.tx_zero &&
                       (st_q.tx_tick >= `IPC_PULSE_FIRST) && (st_q.tx_tick <= `IPC_PULSE_LAST);

    always_comb begin
        st_d = st_q;
        st_d.clk_d1 = clk_s;
        if (tick) begin
            case (st_q.tx_st)
                IPC_IDLE: begin
                    // A receive pulse on the same tick wins, so both sides never start together
                    if (!host_tx_s && ir_in_s && st_q.rx_st == IPC_IDLE) begin
                        st_d.tx_st = IPC_BUSY;
                        st_d.tx_tick = 4'h0;
                        st_d.tx_bit = 4'h0;
                        st_d.tx_zero = 1'b1;
                    end
                end
                IPC_BUSY: begin
                    st_d.tx_tick = st_q.tx_tick + 4'h1;
                    if (st_q.tx_tick == `IPC_TICK_LAST) begin
                        st_d.tx_bit = st_q.tx_bit + 4'h1;
                        st_d.tx_zero = ~host_tx_s;
                        if (st_q.tx_bit == `IPC_FRAME_LAST) begin
                            st_d.tx_st = IPC_IDLE;
                        end
                    end
                end
                default: begin
                    st_d.tx_st = IPC_IDLE;
                end
            endcase
            case (st_q.rx_st)
                IPC_IDLE: begin
                    if (!ir_in_s && st_q.tx_st == IPC_IDLE) begin
                        st_d.rx_st = IPC_BUSY;
                        st_d.rx_tick = 4'h0;
                        st_d.rx_bit = 4'h0;
                        st_d.host_rx = 1'b0;
                    end
                end
                IPC_BUSY: begin
                    st_d.rx_tick = st_q.rx_tick + 4'h1;
                    if (st_q.rx_tick == `IPC_TICK_LAST) begin
                        st_d.rx_bit = st_q.rx_bit + 4'h1;
                        st_d.host_rx = ir_in_s;
                        if (st_q.rx_bit == `IPC_FRAME_LAST) begin
                            st_d.rx_st = IPC_IDLE;
                            st_d.host_rx = 1'b1;
                        end
                    end else if (st_q.rx_tick <= `IPC_RX_WIN_LAST && !ir_in_s) begin
                        // A pulse that trails the bit edge still marks a zero
                        st_d.host_rx = 1'b0;
                    end
                end
                default: begin
                    st_d.rx_st = IPC_IDLE;
                end
            endcase
        end
        // Limiter counts real clock cycles so it holds at any bit clock rate
        if (pulse_win && st_q.lim_cnt != LimitCnt) begin
            st_d.lim_cnt = st_q.lim_cnt + 1'b1;
        end else if (!pulse_win) begin
            st_d.lim_cnt = '0;
        end
        st_d.ir_out = pulse_win && (st_q.lim_cnt != LimitCnt) && ir_in_s;
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            // Everything parked: no counting while held
            st_q <= '0;
            st_q.host_rx <= 1'b1;
            // Matches the synchroniser's reset level so no false tick follows release
            st_q.clk_d1 <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign host_rx_o = st_q.host_rx;
    assign ir_pulse_out_o = st_q.ir_out;

    // Checks
    logic [`IPC_LIM_W:0] hi_run;
    always_ff @(posedge clock_i) begin
        if (rst_i || !st_q.ir_out) begin
            hi_run <= '0;
        end else begin
            hi_run <= hi_run + 1'b1;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    a_pulse_limit: assert property (hi_run <= {1'b0, LimitCnt})
        else $error("transmit pulse exceeded limiter");
    a_half_duplex: assert property (!(st_q.tx_st == IPC_BUSY && st_q.rx_st == IPC_BUSY))
        else $error("transmit and receive both active");
    a_rx_blocks_tx: assert property (!ir_in_s |=> !ir_pulse_out_o)
        else $error("transmit pulse during receive pulse");
    a_rx_cuts_pulse: assert property (ir_pulse_out_o && !ir_in_s |=> !ir_pulse_out_o)
        else $error("receive pulse did not cut transmit pulse");
    a_tx_start: assert property (tick && st_q.tx_st == IPC_IDLE && !host_tx_s && ir_in_s
        && st_q.rx_st == IPC_IDLE |=> st_q.tx_st == IPC_BUSY && st_q.tx_tick == 4'h0)
        else $error("start bit not taken");
    a_rx_start: assert property (tick && st_q.rx_st == IPC_IDLE && !ir_in_s
        && st_q.tx_st == IPC_IDLE |=> !host_rx_o)
        else $error("decoded start bit not aligned");
    a_one_no_pulse: assert property (st_q.tx_st == IPC_BUSY && !st_q.tx_zero
        |-> !ir_pulse_out_o)
        else $error("pulse sent for a one bit");
    a_pulse_window: assert property (ir_pulse_out_o |-> st_q.tx_tick >= `IPC_PULSE_FIRST
        && st_q.tx_tick <= `IPC_PULSE_LAST + 4'h1)
        else $error("pulse outside its window");
    a_rx_idle_high: assert property (st_q.rx_st == IPC_IDLE && $past(st_q.rx_st) == IPC_IDLE
        |-> host_rx_o)
        else $error("host output low while decoder idle");
    a_reset_levels: assert property (@(posedge clock_i) disable iff (1'b0)
        $past(rst_i) |-> host_rx_o && !ir_pulse_out_o)
        else $error("outputs wrong after reset");
endmodule : ipc_codec

//--- ipc_far_end.sv
// Host serial line and infrared transceiver model facing the codec
module ipc_far_end (
    input wire logic clock_i,
    output logic bit_clock_x16_o,
    output logic host_tx_o,
    output logic ir_pulse_in_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int half = 4;
    // Bit clock keeps running after reset release; half period may change between frames
    initial begin
        bit_clock_x16_o = 1'b0;
        host_tx_o = 1'b1;
        ir_pulse_in_o = 1'b1;
        forever begin
            repeat (half) @(negedge clock_i);
            bit_clock_x16_o = ~bit_clock_x16_o;
        end
    end
    task automatic send_host(input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge bit_clock_x16_o);
            host_tx_o = f[i];
            repeat (15) @(posedge bit_clock_x16_o);
        end
    endtask : send_host
    // A zero is a low pulse of three sub-bit clocks at the bit start
    task automatic send_ir(input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge bit_clock_x16_o);
            ir_pulse_in_o = f[i];
            repeat (3) @(posedge bit_clock_x16_o);
            ir_pulse_in_o = 1'b1;
            repeat (12) @(posedge bit_clock_x16_o);
        end
    endtask : send_ir
endmodule : ipc_far_end

//--- ipc_codec_test.sv
// Self-checking bench for the infrared pulse codec
module ipc_codec_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic bclk, htx, irin, rx, ir;
    int n_errors = 0;
    int num_checks = 0;
    int cyc = 0;
    int last = 0;
    int gap = 0;
    int hi = 0;
    int width = 0;
    int rises = 0;
    ipc_far_end p (.clock_i(clock_i), .bit_clock_x16_o(bclk), .host_tx_o(htx),
        .ir_pulse_in_o(irin));
    ipc_codec uut (.clock_i(clock_i), .rst_i(rst_i), .bit_clock_x16_i(bclk),
        .host_tx_i(htx), .ir_pulse_in_i(irin), .host_rx_o(rx), .ir_pulse_out_o(ir));
    initial begin
        forever #4 clock_i = ~clock_i;
    end
    // Width of the last pulse and spacing of the last two rises, in clock cycles
    always @(negedge clock_i) begin
        cyc++;
        if (ir === 1'b1) begin
            if (hi == 0) begin
                rises++;
                gap = cyc - last;
                last = cyc;
            end
            hi++;
        end else if (hi != 0) begin
            width = hi;
            hi = 0;
        end
        if (cyc == 20000) begin
            n_errors++;
            wrap_up();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up();
        $display("Checks %0d, errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up
    task automatic t_hold();
        @(negedge clock_i);
        rst_i = 1'b1;
        p.host_tx_o = 1'b0;
        repeat (100) begin
            @(negedge clock_i);
            check(ir, 1'b0);
            check(rx, 1'b1);
        end
        p.host_tx_o = 1'b1;
        repeat (4) @(negedge clock_i);
        rst_i = 1'b0;
        repeat (8) @(negedge clock_i);
    endtask : t_hold
    task automatic t_tx(input logic [7:0] d, input int n, input int g);
        rises = 0;
        p.send_host(d);
        repeat (40) @(negedge clock_i);
        check(rises, n);
        check(width, 24);
        check(gap, g);
    endtask : t_tx
    task automatic t_rx(input logic [7:0] d);
        logic [9:0] got;
        int t0;
        fork
            p.send_ir(d);
            begin
                @(negedge irin);
                t0 = cyc;
                for (int i = 0; i < 20 && rx !== 1'b0; i++)
                    @(negedge clock_i);
                check((cyc - t0) inside {[1:13]}, 1'b1);
                repeat (64) @(negedge clock_i);
                for (int i = 0; i < 10; i++) begin
                    got[i] = rx;
                    repeat (128) @(negedge clock_i);
                end
            end
        join
        check(got, {1'b1, d, 1'b0});
        check(rx, 1'b1);
    endtask : t_rx
    // Receive pulse lands inside a transmit pulse; the decoder must not start either
    task automatic t_clash();
        fork
            p.send_host(8'h00);
            begin
                for (int i = 0; i < 400 && ir !== 1'b1; i++)
                    @(negedge clock_i);
                check(ir, 1'b1);
                p.ir_pulse_in_o = 1'b0;
                repeat (4) @(negedge clock_i);
                repeat (30) begin
                    @(negedge clock_i);
                    check(ir, 1'b0);
                    check(rx, 1'b1);
                end
                p.ir_pulse_in_o = 1'b1;
            end
        join
        repeat (40) @(negedge clock_i);
    endtask : t_clash
    // Slow bit clock: three sub-bit clocks outlast the 500-cycle limiter
    task automatic t_limit();
        p.half = 100;
        width = 0;
        fork
            p.send_host(8'hFE);
            for (int i = 0; i < 4000 && width == 0; i++)
                @(negedge clock_i);
        join_any
        disable fork;
        check(width, 500);
        p.half = 4;
        t_hold();
    endtask : t_limit
    initial begin
        repeat (20) @(negedge clock_i);
        rst_i = 1'b0;
        repeat (8) @(negedge clock_i);
        t_tx(8'h00, 9, 128);
        t_tx(8'h55, 5, 256);
        t_rx(8'hA5);
        t_clash();
        t_limit();
        t_tx(8'h0F, 5, 128);
        wrap_up();
    end
endmodule : ipc_codec_test
